// *** logic/limit_alert_regs.vh ***
// register offsets, field positions and reset values of the limit/alert block
// included by limit_alert_diag_flags.v only
`ifndef LIMIT_ALERT_REGS_VH
`define LIMIT_ALERT_REGS_VH

`define DIAG_OFFSET        8'h0b
`define SHUNT_OVER_LIMIT_THRESHOLD_OFFSET        8'h0c

`define DIAG_LATCH_BIT     15
`define DIAG_READY_EN_BIT  14
`define DIAG_AVG_SEL_BIT   13
`define DIAG_POL_BIT       12
`define DIAG_MATH_OVERFLOW_FLAG_BIT    9
`define DIAG_TEMP_BIT      7
`define DIAG_SHNT_OV_BIT   6
`define DIAG_SHNT_UN_BIT   5
`define DIAG_BUS_OV_BIT    4
`define DIAG_BUS_UN_BIT    3
`define DIAG_PWR_OV_BIT    2
`define DIAG_READY_BIT     1
`define DIAG_MEM_BIT       0

`define SHUNT_OVER_LIMIT_THRESHOLD_RESET         16'h7fff
`define MEM_OK_RESET       1'b1
`define DEV_ADDR_DEFAULT   7'h40
`define BYTE_LAST          3'h7
`define PWR_LIMIT_PAD      8'h00

`endif

// *** logic/limit_alert_diag_flags.v ***
// limit comparison, diagnostic flags, open-drain alert and i2c register slave
// assumes measurement inputs and strobes come from logic on clk_i, and that
// scl/sda arrive asynchronously from the bus; scl is well below clk_i/4
`timescale 1ns/1ps
`include "limit_alert_regs.vh"

module limit_alert_diag_flags #(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        srst_i,
    // i2c pins (open drain sda)
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_n_o,
    // alert pin (open drain)
    output reg         alert_o,
    output reg         alert_oe_n_o,
    // raw conversion results
    input  wire        raw_valid_i,
    input  wire [15:0] shunt_raw_i,
    input  wire [14:0] bus_raw_i,
    input  wire [11:0] temp_raw_i,
    input  wire [23:0] power_raw_i,
    // averaged conversion results
    input  wire        avg_valid_i,
    input  wire [15:0] shunt_avg_i,
    input  wire [14:0] bus_avg_i,
    input  wire [11:0] temp_avg_i,
    input  wire [23:0] power_avg_i,
    // thresholds held elsewhere
    input  wire [15:0] shunt_under_threshold_i,
    input  wire [14:0] bus_over_threshold_i,
    input  wire [14:0] bus_under_threshold_i,
    input  wire [11:0] temp_over_threshold_i,
    input  wire [15:0] power_over_threshold_i,
    // conversion engine events
    input  wire        conversion_start_i,
    input  wire        conversion_done_i,
    input  wire        math_overflow_i,
    input  wire        checksum_error_i,
    // status to the rest of the device
    output reg  [15:0] shunt_over_threshold_o,
    output reg         shunt_range_select_o
);

    localparam [8:0] ST_IDLE  = 9'h001;
    localparam [8:0] ST_ADDR  = 9'h002;
    localparam [8:0] ST_ACK_A = 9'h004;
    localparam [8:0] ST_PTR   = 9'h008;
    localparam [8:0] ST_ACK_P = 9'h010;
    localparam [8:0] ST_WDATA = 9'h020;
    localparam [8:0] ST_ACK_W = 9'h040;
    localparam [8:0] ST_RDATA = 9'h080;
    localparam [8:0] ST_RACK  = 9'h100;

    // pin synchronisers; stage three only feeds edge detection
    reg        scl_m;
    reg        scl_s;
    reg        scl_d;
    reg        sda_m;
    reg        sda_s;
    reg        sda_d;

    // configuration and flags
    reg        alert_latch_mode;
    reg        ready_on_alert_enable;
    reg        averaged_compare_select;
    reg        alert_polarity;
    reg        math_overflow_flag;
    reg        over_temperature_flag;
    reg        shunt_over_limit_flag;
    reg        shunt_under_limit_flag;
    reg        bus_over_limit_flag;
    reg        bus_under_limit_flag;
    reg        power_over_limit_flag;
    reg        conversion_ready_flag;
    reg        trim_memory_status;
    reg [15:0] shunt_over_threshold;

    // i2c engine
    reg [8:0]  state;
    reg [2:0]  bit_cnt;
    reg [7:0]  shift_in;
    reg [7:0]  shift_out;
    reg [7:0]  ptr;
    reg [7:0]  wr_hi;
    reg        rw_bit;
    // set by the eighth rising scl of a byte, so a stale shift value after a
    // start is never taken for a finished byte
    reg        byte_done;
    reg        hi_byte;
    reg [7:0]  rd_lo;
    reg        read_clear;

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

    wire [15:0] diag_flag_register = {alert_latch_mode, ready_on_alert_enable,
        averaged_compare_select, alert_polarity,
        2'b00,
        math_overflow_flag, 1'b0, over_temperature_flag,
        shunt_over_limit_flag, shunt_under_limit_flag, bus_over_limit_flag,
        bus_under_limit_flag, power_over_limit_flag, conversion_ready_flag,
        trim_memory_status};

    function [15:0] reg_read;
        input [7:0] addr;
        begin
            case (addr)
                `DIAG_OFFSET: reg_read = diag_flag_register;
                `SHUNT_OVER_LIMIT_THRESHOLD_OFFSET: reg_read = shunt_over_threshold;
                default:      reg_read = 16'h0000;
            endcase
        end
    endfunction

    wire [15:0] rd_word = reg_read(ptr);

    // transparent: flag follows the latest compare; latched: sticky until read,
    // and a compare that trips in the read cycle wins over the clear
    function upd;
        input f;
        input c;
        input stb;
        input latch;
        input clr;
        begin
            if (latch)
                upd = (f & ~clr) | (stb & c);
            else
                upd = stb ? c : f;
        end
    endfunction

    // compare source selection
    wire        cmp_stb   = averaged_compare_select ? avg_valid_i : raw_valid_i;
    wire [15:0] shunt_v   = averaged_compare_select ? shunt_avg_i : shunt_raw_i;
    wire [14:0] bus_v     = averaged_compare_select ? bus_avg_i   : bus_raw_i;
    wire [11:0] temp_v    = averaged_compare_select ? temp_avg_i  : temp_raw_i;
    wire [23:0] power_v   = averaged_compare_select ? power_avg_i : power_raw_i;

    // shunt and temperature compares signed, bus and power unsigned: a negative over threshold already trips at zero shunt
    wire c_temp  = $signed(temp_v) > $signed(temp_over_threshold_i);
    wire c_sh_ov = $signed(shunt_v) > $signed(shunt_over_threshold);
    wire c_sh_un = $signed(shunt_v) < $signed(shunt_under_threshold_i);
    wire c_bu_ov = bus_v > bus_over_threshold_i;
    wire c_bu_un = bus_v < bus_under_threshold_i;
    wire c_pwr   = power_v > {power_over_threshold_i, `PWR_LIMIT_PAD};

    wire alert_active = over_temperature_flag | shunt_over_limit_flag |
        shunt_under_limit_flag | bus_over_limit_flag | bus_under_limit_flag |
        power_over_limit_flag |
        (conversion_ready_flag & ready_on_alert_enable);

    always @(posedge clk_i) begin
        if (srst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // event flags
    always @(posedge clk_i) begin
        if (srst_i) begin
            math_overflow_flag     <= 1'b0;
            over_temperature_flag  <= 1'b0;
            shunt_over_limit_flag  <= 1'b0;
            shunt_under_limit_flag <= 1'b0;
            bus_over_limit_flag    <= 1'b0;
            bus_under_limit_flag   <= 1'b0;
            power_over_limit_flag  <= 1'b0;
            conversion_ready_flag  <= 1'b0;
            trim_memory_status     <= `MEM_OK_RESET;
        end else begin
            // only the overflow event sets it, only a new conversion clears it
            math_overflow_flag <= (math_overflow_flag & ~conversion_start_i)
                                  | math_overflow_i;
            over_temperature_flag  <= upd(over_temperature_flag, c_temp, cmp_stb,
                                          alert_latch_mode, read_clear);
            shunt_over_limit_flag  <= upd(shunt_over_limit_flag, c_sh_ov, cmp_stb,
                                          alert_latch_mode, read_clear);
            shunt_under_limit_flag <= upd(shunt_under_limit_flag, c_sh_un, cmp_stb,
                                          alert_latch_mode, read_clear);
            bus_over_limit_flag    <= upd(bus_over_limit_flag, c_bu_ov, cmp_stb,
                                          alert_latch_mode, read_clear);
            bus_under_limit_flag   <= upd(bus_under_limit_flag, c_bu_un, cmp_stb,
                                          alert_latch_mode, read_clear);
            power_over_limit_flag  <= upd(power_over_limit_flag, c_pwr, cmp_stb,
                                          alert_latch_mode, read_clear);
            if (alert_latch_mode)
                conversion_ready_flag <= (conversion_ready_flag & ~read_clear
                    & ~conversion_start_i) | conversion_done_i;
            else
                conversion_ready_flag <= (conversion_ready_flag & ~conversion_start_i)
                    | conversion_done_i;
            if (checksum_error_i)
                trim_memory_status <= 1'b0;
        end
    end

    // alert pin: data always low, enable low while pulling the wire down
    always @(posedge clk_i) begin
        if (srst_i) begin
            alert_o      <= 1'b0;
            alert_oe_n_o <= 1'b1;
        end else begin
            alert_o      <= 1'b0;
            alert_oe_n_o <= ~(alert_active ^ alert_polarity);
        end
    end

    // i2c slave: sample on scl rise, change sda on scl fall
    always @(posedge clk_i) begin
        if (srst_i) begin
            state                   <= ST_IDLE;
            bit_cnt                 <= 3'h0;
            shift_in                <= 8'h00;
            shift_out               <= 8'h00;
            ptr                     <= 8'h00;
            wr_hi                   <= 8'h00;
            rw_bit                  <= 1'b0;
            byte_done               <= 1'b0;
            hi_byte                 <= 1'b1;
            rd_lo                   <= 8'h00;
            read_clear              <= 1'b0;
            sda_o                   <= 1'b0;
            sda_oe_n_o              <= 1'b1;
            alert_latch_mode        <= 1'b0;
            ready_on_alert_enable   <= 1'b0;
            averaged_compare_select <= 1'b0;
            alert_polarity          <= 1'b0;
            shunt_over_threshold    <= `SHUNT_OVER_LIMIT_THRESHOLD_RESET;
        end else begin
            read_clear <= 1'b0;
            sda_o      <= 1'b0;
            if (stop_c) begin
                state      <= ST_IDLE;
                sda_oe_n_o <= 1'b1;
            end else if (start_c) begin
                state      <= ST_ADDR;
                bit_cnt    <= 3'h0;
                byte_done  <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else if (scl_rise) begin
                if ((state & (ST_ADDR | ST_PTR | ST_WDATA)) != 9'h000) begin
                    shift_in  <= {shift_in[6:0], sda_s};
                    bit_cnt   <= bit_cnt + 3'h1;
                    byte_done <= (bit_cnt == `BYTE_LAST);
                end else if (state == ST_RACK) begin
                    rw_bit <= sda_s;    // reused: 1 means the master sent nack
                end
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            if (shift_in[7:1] == DEV_ADDR) begin
                                rw_bit     <= shift_in[0];
                                sda_oe_n_o <= 1'b0;
                                state      <= ST_ACK_A;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK_A: begin
                        if (rw_bit) begin
                            hi_byte    <= 1'b0;
                            shift_out  <= rd_word[15:8];
                            rd_lo      <= rd_word[7:0];
                            read_clear <= (ptr == `DIAG_OFFSET);
                            sda_oe_n_o <= rd_word[15];
                            state      <= ST_RDATA;
                        end else begin
                            sda_oe_n_o <= 1'b1;
                            state      <= ST_PTR;
                        end
                        bit_cnt <= 3'h0;
                    end
                    ST_PTR: begin
                        if (byte_done) begin
                            byte_done  <= 1'b0;
                            ptr        <= shift_in;
                            sda_oe_n_o <= 1'b0;
                            state      <= ST_ACK_P;
                        end
                    end
                    ST_ACK_P: begin
                        sda_oe_n_o <= 1'b1;
                        hi_byte    <= 1'b1;
                        state      <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            if (hi_byte) begin
                                wr_hi <= shift_in;
                            end else if (ptr == `DIAG_OFFSET) begin
                                // flag bits are not writable
                                alert_latch_mode        <= wr_hi[`DIAG_LATCH_BIT - 8];
                                ready_on_alert_enable   <= wr_hi[`DIAG_READY_EN_BIT - 8];
                                averaged_compare_select <= wr_hi[`DIAG_AVG_SEL_BIT - 8];
                                alert_polarity          <= wr_hi[`DIAG_POL_BIT - 8];
                            end else if (ptr == `SHUNT_OVER_LIMIT_THRESHOLD_OFFSET) begin
                                shunt_over_threshold <= {wr_hi, shift_in};
                            end
                            sda_oe_n_o <= 1'b0;
                            state      <= ST_ACK_W;
                        end
                    end
                    ST_ACK_W: begin
                        sda_oe_n_o <= 1'b1;
                        hi_byte    <= ~hi_byte;
                        state      <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (bit_cnt == `BYTE_LAST) begin
                            sda_oe_n_o <= 1'b1;
                            state      <= ST_RACK;
                        end else begin
                            sda_oe_n_o <= shift_out[6];
                            shift_out  <= {shift_out[6:0], 1'b0};
                        end
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    ST_RACK: begin
                        if (rw_bit) begin
                            state <= ST_IDLE;
                        end else begin
                            // after the low byte the same register repeats
                            shift_out  <= hi_byte ? rd_word[15:8] : rd_lo;
                            sda_oe_n_o <= hi_byte ? rd_word[15] : rd_lo[7];
                            rd_lo      <= hi_byte ? rd_word[7:0] : rd_lo;
                            read_clear <= hi_byte & (ptr == `DIAG_OFFSET);
                            hi_byte    <= ~hi_byte;
                            bit_cnt    <= 3'h0;
                            state      <= ST_RDATA;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            shunt_over_threshold_o <= `SHUNT_OVER_LIMIT_THRESHOLD_RESET;
            shunt_range_select_o   <= 1'b0;
        end else begin
            shunt_over_threshold_o <= shunt_over_threshold;
            shunt_range_select_o   <= 1'b0;
        end
    end

endmodule // limit_alert_diag_flags

// *** test/limit_alert_chk.sv ***
// pin-level assertions for the limit/alert block, bound into every instance
// assumes one clk_i domain with srst_i as its synchronous reset
`timescale 1ns/1ps

module limit_alert_chk (
    // clock and reset
    input wire        clk_i,
    input wire        srst_i,
    // bus and alert pins
    input wire        scl_i,
    input wire        sda_i,
    input wire        sda_o,
    input wire        sda_oe_n_o,
    input wire        alert_o,
    input wire        alert_oe_n_o,
    // events and status
    input wire        raw_valid_i,
    input wire        avg_valid_i,
    input wire        conversion_start_i,
    input wire        conversion_done_i,
    input wire        math_overflow_i,
    input wire [15:0] shunt_over_threshold_o,
    input wire        shunt_range_select_o
);
    // bus idle long enough that no register access can still land
    reg  [3:0] idle_cnt;
    wire       ev = raw_valid_i | avg_valid_i | conversion_start_i
                    | conversion_done_i | math_overflow_i;

    always @(posedge clk_i) begin
        if (srst_i || !scl_i || !sda_i) idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence rel_s; $fell(srst_i); endsequence
    sequence calm_s; (idle_cnt == 4'hf && !ev) [*3]; endsequence

    sda_low_a: assert property (sda_o == 1'b0)
        else $error("sda data output not low");
    alert_low_a: assert property (alert_o == 1'b0)
        else $error("alert data output not low");
    range_zero_a: assert property (shunt_range_select_o == 1'b0)
        else $error("range select not zero");
    reset_state_a: assert property (rel_s |-> alert_oe_n_o && sda_oe_n_o
        && shunt_over_threshold_o == 16'h7fff) else $error("bad state after reset");
    alert_calm_a: assert property (calm_s |=> $stable(alert_oe_n_o))
        else $error("alert moved with no cause");
    alert_cause_a: assert property (idle_cnt == 4'hf && $changed(alert_oe_n_o)
        |-> $past(ev, 2)) else $error("alert change not two cycles after event");
    thr_hold_a: assert property (idle_cnt == 4'hf |-> $stable(shunt_over_threshold_o))
        else $error("threshold changed without bus access");
    sda_turn_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("sda changed while scl high");
endmodule // limit_alert_chk

bind limit_alert_diag_flags limit_alert_chk u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o),
    .raw_valid_i(raw_valid_i), .avg_valid_i(avg_valid_i),
    .conversion_start_i(conversion_start_i), .conversion_done_i(conversion_done_i),
    .math_overflow_i(math_overflow_i), .shunt_over_threshold_o(shunt_over_threshold_o),
    .shunt_range_select_o(shunt_range_select_o)
);

// *** test/i2c_host_model.sv ***
// i2c host model: drives scl and pulls sda low, 160 ns bit period
// assumes the bench resolves sda with a pull-up and feeds the level back
`timescale 1ns/1ps

module i2c_host_model #(
    parameter [6:0] ADDR = 7'h40
) (
    // clock
    input  wire clk_i,
    // bus
    input  wire sda_i,
    output reg  scl_o,
    output reg  pull_o
);
    reg [7:0] r;
    reg       a;

    // scl stands high between frames
    initial begin
        scl_o  = 1'b1;
        pull_o = 1'b0;
    end

    task q;
        repeat (4) @(posedge clk_i);
    endtask

    // sda only moves while scl is low
    task bit_io(input b, output rb);
        pull_o <= ~b;
        q;
        scl_o <= 1'b1;
        q;
        rb = sda_i;
        q;
        scl_o <= 1'b0;
        q;
    endtask

    task start;
        pull_o <= 1'b0;
        q;
        scl_o <= 1'b1;
        q;
        pull_o <= 1'b1;
        q;
        scl_o <= 1'b0;
        q;
    endtask

    task stop;
        pull_o <= 1'b1;
        q;
        scl_o <= 1'b1;
        q;
        pull_o <= 1'b0;
        q;
    endtask

    task byte_io(input [7:0] d, input ab, output [7:0] rd_b, output ack);
        integer i;
        reg     s;
        for (i = 7; i >= 0; i = i - 1) bit_io(d[i], rd_b[i]);
        bit_io(ab, s);
        ack = ~s;
    endtask

    task head(input [7:0] p);
        start;
        byte_io({ADDR, 1'b0}, 1'b1, r, a);
        byte_io(p, 1'b1, r, a);
    endtask

    task wr(input [7:0] p, input [15:0] v);
        head(p);
        byte_io(v[15:8], 1'b1, r, a);
        byte_io(v[7:0], 1'b1, r, a);
        stop;
    endtask

    task rd(input [7:0] p, output [15:0] v);
        head(p);
        start;
        byte_io({ADDR, 1'b1}, 1'b1, r, a);
        byte_io(8'hff, 1'b0, v[15:8], a);
        byte_io(8'hff, 1'b1, v[7:0], a);
        stop;
    endtask

    task probe(input [6:0] a7, output ack);
        start;
        byte_io({a7, 1'b0}, 1'b1, r, ack);
        stop;
    endtask
endmodule // i2c_host_model

// *** test/tb.sv ***
// self-checking bench for the limit/alert block driven by an i2c host model
// assumes the block answers at its default bus address 7'h40
`timescale 1ns/1ps

module tb;
    logic        clk_i, srst_i, ack, scl, pull, sda_o, sda_oe_n_o, alert_o, alert_oe_n_o, rng_o;
    logic [5:0]  evm, ex;
    logic [15:0] sh, v, thr_o;
    logic [14:0] bu;
    logic [11:0] te;
    logic [23:0] pw;
    logic [72:0] rows [0:8];
    integer      failures = 0, total_checks = 0, cycles = 0, i;
    wire         sda = ~pull & (sda_oe_n_o | sda_o);

    limit_alert_diag_flags u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o),
        .raw_valid_i(evm[5]), .shunt_raw_i(sh), .bus_raw_i(bu), .temp_raw_i(te),
        .power_raw_i(pw), .avg_valid_i(evm[4]), .shunt_avg_i(sh), .bus_avg_i(bu),
        .temp_avg_i(te), .power_avg_i(pw), .shunt_under_threshold_i(16'hff00),
        .bus_over_threshold_i(15'h1000), .bus_under_threshold_i(15'h0100),
        .temp_over_threshold_i(12'h100), .power_over_threshold_i(16'h0010),
        .conversion_start_i(evm[3]), .conversion_done_i(evm[2]), .math_overflow_i(evm[1]),
        .checksum_error_i(evm[0]), .shunt_over_threshold_o(thr_o), .shunt_range_select_o(rng_o)
    );
    i2c_host_model u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures = failures + 1;
            summarize;
        end
    end

    task summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task chk(input string n, input [15:0] g, input [15:0] e);
        total_checks = total_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task rchk(input string n, input [7:0] p, input [15:0] m, input [15:0] e);
        u_host.rd(p, v);
        chk(n, v & m, e);
    endtask

    task achk(input e);
        chk("alert pin", {15'h0, alert_oe_n_o}, {15'h0, e});
    endtask

    // bus left idle first so the pin checker can tie the alert to this event
    task ev(input [5:0] m, input [15:0] s);
        repeat (16) @(posedge clk_i);
        evm <= m;
        sh  <= s;
        @(posedge clk_i);
        evm <= 6'h0;
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    initial begin
        // shunt, bus, temperature, power, expected flags 7:2
        rows[0] = {16'h0000, 15'h0800, 12'h000, 24'h000800, 6'b000000};
        rows[1] = {16'h0101, 15'h0800, 12'h000, 24'h000800, 6'b010000};
        rows[2] = {16'h0100, 15'h0800, 12'h000, 24'h000800, 6'b000000};
        rows[3] = {16'hfeff, 15'h0800, 12'h000, 24'h000800, 6'b001000};
        rows[4] = {16'h0000, 15'h1001, 12'h000, 24'h000800, 6'b000100};
        rows[5] = {16'h0000, 15'h00ff, 12'h000, 24'h000800, 6'b000010};
        rows[6] = {16'h0000, 15'h0800, 12'h101, 24'h000800, 6'b100000};
        rows[7] = {16'h0000, 15'h0800, 12'hfff, 24'h001001, 6'b000001};
        rows[8] = {16'h0000, 15'h1000, 12'h000, 24'h001000, 6'b000000};
        srst_i = 1'b1;
        evm = 6'h0;
        sh = 16'h0;
        {bu, te, pw} = {15'h0800, 12'h000, 24'h000800};
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        achk(1'b1);
        rchk("threshold reset", 8'h0c, 16'hffff, 16'h7fff);
        rchk("flags reset", 8'h0b, 16'hffff, 16'h0001);
        u_host.wr(8'h0c, 16'h0100);
        for (i = 0; i < 9; i = i + 1) begin
            @(posedge clk_i);
            {bu, te, pw, ex} <= rows[i][56:0];
            ev(6'h20, rows[i][72:57]);
            achk(ex == 6'h0);
            u_host.rd(8'h0b, v);
            chk("limit flags", {10'h0, v[7:2]}, {10'h0, ex});
            chk("reserved bits", {14'h0, v[11:10]}, 16'h0);
        end
        u_host.wr(8'h0c, 16'hfff0);
        ev(6'h20, 16'h0000);
        rchk("negative limit", 8'h0b, 16'h0040, 16'h0040);
        u_host.wr(8'h0c, 16'h0100);
        ev(6'h20, 16'h0000);
        u_host.wr(8'h0b, 16'h2000);
        ev(6'h20, 16'h0200);
        rchk("raw ignored", 8'h0b, 16'h0040, 16'h0000);
        ev(6'h10, 16'h0200);
        rchk("averaged used", 8'h0b, 16'h0040, 16'h0040);
        ev(6'h10, 16'h0000);
        u_host.wr(8'h0b, 16'h8000);
        ev(6'h20, 16'h0200);
        ev(6'h20, 16'h0000);
        achk(1'b0);
        rchk("latched flag", 8'h0b, 16'h0040, 16'h0040);
        rchk("read clears", 8'h0b, 16'h0040, 16'h0000);
        achk(1'b1);
        ev(6'h04, 16'h0000);
        rchk("ready set", 8'h0b, 16'h0002, 16'h0002);
        rchk("ready read", 8'h0b, 16'h0002, 16'h0000);
        ev(6'h04, 16'h0000);
        ev(6'h08, 16'h0000);
        rchk("ready start", 8'h0b, 16'h0002, 16'h0000);
        u_host.wr(8'h0b, 16'h1000);
        achk(1'b0);
        ev(6'h20, 16'h0200);
        achk(1'b1);
        ev(6'h20, 16'h0000);
        u_host.wr(8'h0b, 16'h4000);
        ev(6'h04, 16'h0000);
        achk(1'b0);
        ev(6'h08, 16'h0000);
        achk(1'b1);
        ev(6'h02, 16'h0000);
        rchk("overflow set", 8'h0b, 16'h0200, 16'h0200);
        u_host.wr(8'h0b, 16'h00fc);
        rchk("host write", 8'h0b, 16'h02fc, 16'h0200);
        ev(6'h08, 16'h0000);
        rchk("overflow clear", 8'h0b, 16'h0200, 16'h0000);
        ev(6'h01, 16'h0000);
        rchk("trim status", 8'h0b, 16'h0001, 16'h0000);
        rchk("unmapped", 8'h3f, 16'hffff, 16'h0000);
        u_host.probe(7'h41, ack);
        chk("foreign address", {15'h0, ack}, 16'h0);
        u_host.probe(7'h40, ack);
        chk("own address", {15'h0, ack}, 16'h1);
        chk("range select", {15'h0, rng_o}, 16'h0);
        chk("threshold out", thr_o, 16'h0100);
        summarize;
    end
endmodule // tb
